// ---- osb_regs.vh ----
// register map, field positions, reset values and timing counts of the setpoint bank
`ifndef OSB_REGS_VH
`define OSB_REGS_VH

`define OSB_ADDR_MODE          8'h20
`define OSB_ADDR_NOMINAL       8'h21
`define OSB_ADDR_CAL_OFFSET    8'h23
`define OSB_ADDR_CEILING       8'h24
`define OSB_ADDR_MARGIN_HIGH   8'h25
`define OSB_ADDR_MARGIN_LOW    8'h26
`define OSB_ADDR_SLEW_RATE     8'h27

`define OSB_MODE_VALUE         8'h13
`define OSB_CAL_OFFSET_RST     16'h0000
`define OSB_SLEW_RATE_RST      16'hBA00
`define OSB_SLEW_RATE_FASTEST  16'h7BFF
`define OSB_CEILING_PCT        8'h6E
`define OSB_MARGIN_HIGH_PCT    8'h69
`define OSB_MARGIN_LOW_PCT     8'h5F
`define OSB_PCT_DIV            32'h00000064

`define OSB_OP_ON_HI           7
`define OSB_OP_ON_LO           6
`define OSB_OP_MARGIN_HI       5
`define OSB_OP_MARGIN_LO       4
`define OSB_OP_ON_CODE         2'b10
`define OSB_MARGIN_NOMINAL     2'b00
`define OSB_MARGIN_LOW         2'b01
`define OSB_MARGIN_HIGH        2'b10

`define OSB_RATE_EXP_HI        15
`define OSB_RATE_EXP_LO        11
`define OSB_RATE_MANT_HI       10
`define OSB_VOUT_EXP_SHIFT     13
`define OSB_FRAC_BITS          16
`define OSB_CLK_HZ             10000000
`define OSB_MS_PER_S           1000
`define OSB_CYCLES_PER_MS      (`OSB_CLK_HZ / `OSB_MS_PER_S)

`endif

// ---- osb_setpoint_bank.v ----
// output-voltage setpoint register bank with margin selection, clamp and slew ramp
`timescale 1ns/10ps
`include "osb_regs.vh"
//
// Overview of operation
// - nominal target is unsigned, one lsb equals two to minus thirteen volts.
// - nominal target resets to the pin-strap value.
// - nominal above the ceiling regulates at the ceiling instead.
// - ceiling bounds every ramp destination whatever else is set; a running output above a lowered ceiling ramps down to it.
// - ceiling resets to 1.10 times the strapped nominal, same scaling.
// - signed calibration offset, same scaling, is added to the commanded voltage.
// - margin-high setpoint is the target while operation selects margin high.
// - margin-high resets to 1.05 times the strapped nominal.
// - margin-low setpoint is the target while operation selects margin low.
// - margin-low resets to 0.95 times the strapped nominal.
// - margin changes while running ramp at the slew-rate register, volts per ms.
// - largest positive slew-rate value means jump immediately.
// - slew rate is not used for turn-on or turn-off; only while running.
// - slew rate is linear-11, 5-bit exponent over 11-bit mantissa, resets BA00h.
// - operation bits 7:6 = 10 on; 5:4 = 00 nominal, 01 low, 10 high.
// - read-only mode byte reports linear mode, exponent minus thirteen.

module osb_setpoint_bank
(
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire [15:0] strap_target,
    input  wire        frame_start,
    input  wire [7:0]  cmd_code,
    input  wire        wr_stb,
    input  wire [7:0]  wr_byte,
    input  wire        rd_stb,
    output reg  [7:0]  rd_byte,
    input  wire [7:0]  operation_cmd,
    input  wire        unit_running,
    output reg  [15:0] target_out,
    output reg  [1:0]  margin_state,
    output reg         op_invalid,
    output wire        ramp_active
);

    // scaled strap default, saturating at full scale
    function [15:0] pct_of;
        input [15:0] base;
        input [7:0]  pct;
        reg   [31:0] prod;
        begin
            prod = ({16'h0000, base} * {24'h000000, pct}) / `OSB_PCT_DIV;
            if (prod > 32'h0000FFFF)
                pct_of = 16'hFFFF;
            else
                pct_of = prod[15:0];
        end
    endfunction

    // linear-11 rate to per-cycle step in lsb with 16 fraction bits
    function [31:0] rate_step;
        input [15:0] rate;
        reg signed [6:0]  sh;
        reg signed [10:0] mant;
        reg        [63:0] v;
        begin
            // seven bits: exponent plus 29 reaches 44 and would wrap a six-bit sum
            sh   = $signed({{2{rate[`OSB_RATE_EXP_HI]}}, rate[`OSB_RATE_EXP_HI:`OSB_RATE_EXP_LO]})
                   + 7'sh0D + 7'sh10;
            mant = rate[`OSB_RATE_MANT_HI:0];
            if (mant <= 11'sd0)
                v = 64'h0;
            else
                v = ({53'h0, mant} << sh) / `OSB_CYCLES_PER_MS;
            if (v > 64'h00000000FFFFFFFF)
                rate_step = 32'hFFFFFFFF;
            else
                rate_step = v[31:0];
        end
    endfunction

    function [15:0] clamp_ceil;
        input [15:0] val;
        input [15:0] ceil;
        begin
            clamp_ceil = (val > ceil) ? ceil : val;
        end
    endfunction

    // strap pins are asynchronous to core_clk
    reg [15:0] strap_meta_reg;
    reg [15:0] strap_sync_reg;
    reg        strap_load_reg;
    reg [15:0] strap_ceiling;
    reg [15:0] strap_margin_high;
    reg [15:0] strap_margin_low;

    reg [15:0] nominal_output_target_reg;
    reg [15:0] output_calibration_offset_reg;
    reg [15:0] output_ceiling_limit_reg;
    reg [15:0] upper_margin_target_reg;
    reg [15:0] lower_margin_target_reg;
    reg [15:0] setpoint_slew_rate_reg;

    reg [7:0]  code_reg;
    reg        wr_phase_reg;
    reg [7:0]  wr_low_reg;
    reg        rd_phase_reg;
    reg [7:0]  rd_high_reg;
    reg [15:0] rd_word;
    reg        rd_hit;

    reg [31:0] pos_reg;
    reg [31:0] pos_next;
    reg [15:0] dest;
    reg [15:0] selected;
    reg [17:0] sum;
    reg [31:0] step;
    reg [31:0] step_reg;
    reg [31:0] gap;
    reg [1:0]  margin_next;
    reg        op_bad;

    always @(posedge core_clk)
    begin
        strap_meta_reg <= strap_target;
        strap_sync_reg <= strap_meta_reg;
    end

    // reload the defaults one edge after reset, when the synchroniser is sure to be filled
    always @(posedge core_clk)
    begin
        strap_load_reg <= sys_rst;
    end

    always @*
    begin
        strap_ceiling     = pct_of(strap_sync_reg, `OSB_CEILING_PCT);
        strap_margin_high = pct_of(strap_sync_reg, `OSB_MARGIN_HIGH_PCT);
        strap_margin_low  = pct_of(strap_sync_reg, `OSB_MARGIN_LOW_PCT);
    end

    // step registered so the wide divide stays off the ramp path; a rate write takes effect one cycle late
    always @(posedge core_clk)
    begin
        if (sys_rst)
            step_reg <= rate_step(`OSB_SLEW_RATE_RST);
        else
            step_reg <= rate_step(setpoint_slew_rate_reg);
    end

    // operation byte decode; off states and odd codes keep the last margin
    always @*
    begin
        margin_next = margin_state;
        op_bad      = 1'b0;
        if (operation_cmd[`OSB_OP_ON_HI:`OSB_OP_ON_LO] == `OSB_OP_ON_CODE)
        begin
            case (operation_cmd[`OSB_OP_MARGIN_HI:`OSB_OP_MARGIN_LO])
                `OSB_MARGIN_NOMINAL: margin_next = `OSB_MARGIN_NOMINAL;
                `OSB_MARGIN_LOW:     margin_next = `OSB_MARGIN_LOW;
                `OSB_MARGIN_HIGH:    margin_next = `OSB_MARGIN_HIGH;
                default:             op_bad      = 1'b1;
            endcase
        end
        else if (operation_cmd[`OSB_OP_ON_HI:`OSB_OP_ON_LO] == 2'b11 ||
                 operation_cmd[`OSB_OP_MARGIN_HI:`OSB_OP_MARGIN_LO] != 2'b00)
        begin
            op_bad = 1'b1;
        end
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            margin_state <= `OSB_MARGIN_NOMINAL;
            op_invalid   <= 1'b0;
        end
        else
        begin
            margin_state <= margin_next;
            op_invalid   <= op_bad;
        end
    end

    // write path: low byte held, word committed with the high byte
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            // a short reset may leave these unknown; the first edge after release reloads them
            nominal_output_target_reg     <= strap_sync_reg;
            output_calibration_offset_reg <= `OSB_CAL_OFFSET_RST;
            output_ceiling_limit_reg      <= strap_ceiling;
            upper_margin_target_reg       <= strap_margin_high;
            lower_margin_target_reg       <= strap_margin_low;
            setpoint_slew_rate_reg        <= `OSB_SLEW_RATE_RST;
            code_reg                      <= 8'h00;
            wr_phase_reg                  <= 1'b0;
            wr_low_reg                    <= 8'h00;
        end
        else if (strap_load_reg)
        begin
            // a data strobe here has no frame yet and is dropped
            nominal_output_target_reg <= strap_sync_reg;
            output_ceiling_limit_reg  <= strap_ceiling;
            upper_margin_target_reg   <= strap_margin_high;
            lower_margin_target_reg   <= strap_margin_low;
            if (frame_start)
            begin
                code_reg     <= cmd_code;
                wr_phase_reg <= 1'b0;
            end
        end
        else if (frame_start)
        begin
            code_reg     <= cmd_code;
            wr_phase_reg <= 1'b0;
        end
        else if (wr_stb)
        begin
            if (!wr_phase_reg)
            begin
                wr_low_reg   <= wr_byte;
                wr_phase_reg <= 1'b1;
            end
            else
            begin
                wr_phase_reg <= 1'b0;
                case (code_reg)
                    `OSB_ADDR_NOMINAL:     nominal_output_target_reg     <= {wr_byte, wr_low_reg};
                    `OSB_ADDR_CAL_OFFSET:  output_calibration_offset_reg <= {wr_byte, wr_low_reg};
                    `OSB_ADDR_CEILING:     output_ceiling_limit_reg      <= {wr_byte, wr_low_reg};
                    `OSB_ADDR_MARGIN_HIGH: upper_margin_target_reg       <= {wr_byte, wr_low_reg};
                    `OSB_ADDR_MARGIN_LOW:  lower_margin_target_reg       <= {wr_byte, wr_low_reg};
                    `OSB_ADDR_SLEW_RATE:   setpoint_slew_rate_reg        <= {wr_byte, wr_low_reg};
                    default:               wr_phase_reg                  <= 1'b0;
                endcase
            end
        end
    end

    always @*
    begin
        rd_hit = 1'b1;
        case (code_reg)
            `OSB_ADDR_MODE:        rd_word = {8'h00, `OSB_MODE_VALUE};
            `OSB_ADDR_NOMINAL:     rd_word = nominal_output_target_reg;
            `OSB_ADDR_CAL_OFFSET:  rd_word = output_calibration_offset_reg;
            `OSB_ADDR_CEILING:     rd_word = output_ceiling_limit_reg;
            `OSB_ADDR_MARGIN_HIGH: rd_word = upper_margin_target_reg;
            `OSB_ADDR_MARGIN_LOW:  rd_word = lower_margin_target_reg;
            `OSB_ADDR_SLEW_RATE:   rd_word = setpoint_slew_rate_reg;
            default:
            begin
                rd_word = 16'h0000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // read path: high byte snapshotted with the low one so the word stays coherent
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rd_byte      <= 8'h00;
            rd_phase_reg <= 1'b0;
            rd_high_reg  <= 8'h00;
        end
        else if (frame_start)
        begin
            rd_phase_reg <= 1'b0;
        end
        else if (rd_stb)
        begin
            if (!rd_phase_reg)
            begin
                rd_byte      <= rd_hit ? rd_word[7:0] : 8'h00;
                rd_high_reg  <= rd_word[15:8];
                rd_phase_reg <= 1'b1;
            end
            else
            begin
                rd_byte      <= rd_high_reg;
                rd_phase_reg <= 1'b0;
            end
        end
    end

    // destination: selected setpoint plus signed offset, floored at zero, clamped
    always @*
    begin
        case (margin_state)
            `OSB_MARGIN_HIGH: selected = upper_margin_target_reg;
            `OSB_MARGIN_LOW:  selected = lower_margin_target_reg;
            default:          selected = clamp_ceil(nominal_output_target_reg,
                                                    output_ceiling_limit_reg);
        endcase
        sum = {2'b00, selected} + {{2{output_calibration_offset_reg[15]}},
                                   output_calibration_offset_reg};
        if (sum[17])
            dest = 16'h0000;
        else if (sum[16])
            dest = output_ceiling_limit_reg;
        else
            dest = clamp_ceil(sum[15:0], output_ceiling_limit_reg);
    end

    // ramp position kept with 16 fraction bits so slow rates still advance
    always @*
    begin
        step     = step_reg;
        pos_next = pos_reg;
        gap      = 32'h00000000;
        if (!unit_running || setpoint_slew_rate_reg == `OSB_SLEW_RATE_FASTEST || step == 32'h00000000)
        begin
            // sequencing owns turn-on and turn-off; zero or negative rate would stall
            pos_next = {dest, 16'h0000};
        end
        else if (pos_reg < {dest, 16'h0000})
        begin
            gap      = {dest, 16'h0000} - pos_reg;
            pos_next = (gap <= step) ? {dest, 16'h0000} : pos_reg + step;
        end
        else if (pos_reg > {dest, 16'h0000})
        begin
            gap      = pos_reg - {dest, 16'h0000};
            pos_next = (gap <= step) ? {dest, 16'h0000} : pos_reg - step;
        end
    end

    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pos_reg    <= 32'h00000000;
            target_out <= 16'h0000;
        end
        else
        begin
            pos_reg    <= pos_next;
            target_out <= pos_next[31:16];
        end
    end

    assign ramp_active = (pos_reg != {dest, 16'h0000});

endmodule

// ---- osb_setpoint_bank_monitor.sv ----
// concurrent checks on the setpoint bank ports
`timescale 1ns/10ps
module osb_setpoint_bank_monitor
(
    input wire        core_clk,
    input wire        sys_rst,
    input wire        frame_start,
    input wire [7:0]  cmd_code,
    input wire        rd_stb,
    input wire [7:0]  rd_byte,
    input wire [7:0]  operation_cmd,
    input wire        unit_running,
    input wire [15:0] target_out,
    input wire [1:0]  margin_state,
    input wire        op_invalid,
    input wire        ramp_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_mode_fetch;
        frame_start && cmd_code == 8'h20 ##1 rd_stb && !frame_start;
    endsequence
    sequence s_stopped_gap;
        !unit_running && ramp_active;
    endsequence
    a_mode_low: assert property (s_mode_fetch |=> rd_byte == 8'h13) else $error("mode byte wrong");
    a_nominal_sel: assert property (operation_cmd == 8'h80 |=> margin_state == 2'h0) else $error("no nominal");
    a_low_sel: assert property (operation_cmd == 8'h94 |=> margin_state == 2'h1) else $error("no low");
    a_high_sel: assert property (operation_cmd == 8'hA4 |=> margin_state == 2'h2) else $error("no high");
    a_bad_op: assert property (operation_cmd[7:6] == 2'h3 |=> op_invalid) else $error("no op error");
    a_bad_keeps: assert property (operation_cmd[7:6] == 2'h3 |=> $stable(margin_state)) else $error("margin moved");
    a_settled_hold: assert property (!ramp_active |=> $stable(target_out)) else $error("target drift");
    a_stopped_jump: assert property (s_stopped_gap |=> !ramp_active) else $error("ramp when off");
    a_read_hold: assert property (!rd_stb |=> $stable(rd_byte)) else $error("read byte moved");
endmodule
bind osb_setpoint_bank osb_setpoint_bank_monitor i_osb_setpoint_bank_monitor (.core_clk, .sys_rst, .frame_start,
    .cmd_code, .rd_stb, .rd_byte, .operation_cmd, .unit_running, .target_out, .margin_state, .op_invalid, .ramp_active);

// ---- osb_host_model.sv ----
// management-bus host model driving the register link
`timescale 1ns/10ps
module osb_host_model
(
    input  wire        core_clk,
    input  wire  [7:0] rd_byte,
    output logic       frame_start,
    output logic [7:0] cmd_code,
    output logic       wr_stb,
    output logic [7:0] wr_byte,
    output logic       rd_stb
);
    initial
    begin
        frame_start = 1'h0;
        cmd_code    = 8'h5A;
        wr_stb      = 1'h0;
        wr_byte     = 8'hA5;
        rd_stb      = 1'h0;
    end
    // idle lines carry inverted data so stale values are never mistaken for live ones
    task write_word(input logic [7:0] code, input logic [15:0] data);
        @(posedge core_clk);
        frame_start <= 1'h1;
        cmd_code    <= code;
        @(posedge core_clk);
        frame_start <= 1'h0;
        cmd_code    <= ~code;
        wr_stb      <= 1'h1;
        wr_byte     <= data[7:0];
        @(posedge core_clk);
        wr_byte     <= data[15:8];
        @(posedge core_clk);
        wr_stb      <= 1'h0;
        wr_byte     <= ~data[15:8];
    endtask
    task read_word(input logic [7:0] code, output logic [15:0] data);
        @(posedge core_clk);
        frame_start <= 1'h1;
        cmd_code    <= code;
        @(posedge core_clk);
        frame_start <= 1'h0;
        cmd_code    <= ~code;
        rd_stb      <= 1'h1;
        @(posedge core_clk);
        // both bytes are taken mid-cycle, once the registered read byte has settled
        @(negedge core_clk);
        data[7:0]   = rd_byte;
        @(posedge core_clk);
        rd_stb      <= 1'h0;
        @(negedge core_clk);
        data[15:8]  = rd_byte;
    endtask
endmodule

// ---- osb_setpoint_bank_test.sv ----
// self-checking bench of the setpoint bank
`timescale 1ns/10ps
module osb_setpoint_bank_test;
    logic        core_clk      = 1'h0;
    logic        sys_rst       = 1'h1;
    logic        unit_running  = 1'h0;
    logic [7:0]  operation_cmd = 8'h80;
    logic [15:0] strap_target  = 16'h2000;
    logic [15:0] rd;
    wire         frame_start, wr_stb, rd_stb, op_invalid, ramp_active;
    wire  [7:0]  cmd_code, wr_byte, rd_byte;
    wire  [15:0] target_out;
    wire  [1:0]  margin_state;
    int          bad_count = 0;
    int          n_checks  = 0;
    always #50 core_clk = ~core_clk;
    osb_host_model i_osb_host_model (.core_clk, .rd_byte, .frame_start, .cmd_code, .wr_stb, .wr_byte, .rd_stb);
    osb_setpoint_bank i_osb_setpoint_bank (.core_clk, .sys_rst, .strap_target, .frame_start, .cmd_code, .wr_stb,
        .wr_byte, .rd_stb, .rd_byte, .operation_cmd, .unit_running, .target_out, .margin_state, .op_invalid,
        .ramp_active);
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        i_osb_host_model.write_word(a, d);
    endtask
    task rdchk(input logic [7:0] a, input logic [15:0] e);
        i_osb_host_model.read_word(a, rd);
        chk("register word", e, rd);
    endtask
    task op_set(input logic [7:0] c);
        @(posedge core_clk);
        operation_cmd <= c;
        cycles(3);
    endtask
    task t_defaults;
        logic [7:0]  adr [0:8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
        logic [15:0] exp [0:8] = '{16'h0013, 16'h2000, 16'h0000, 16'h0000, 16'h2333, 16'h2199, 16'h1E66,
                                   16'hBA00, 16'h0000};
        for (int i = 0; i < 9; i++)
            rdchk(adr[i], exp[i]);
        chk("target_out", 16'h2000, target_out);
    endtask
    task t_access;
        wr(8'h20, 16'h5555);
        rdchk(8'h20, 16'h0013);
        wr(8'h27, 16'h1234);
        rdchk(8'h27, 16'h1234);
        wr(8'h27, 16'hBA00);
    endtask
    task t_margins;
        logic [7:0]  code [0:2] = '{8'h80, 8'h94, 8'hA4};
        logic [15:0] tgt [0:2]  = '{16'h2000, 16'h1E66, 16'h2199};
        for (int i = 0; i < 3; i++)
        begin
            op_set(code[i]);
            chk("margin_state", 16'(i), {14'h0000, margin_state});
            chk("target_out", tgt[i], target_out);
        end
        op_set(8'hC0);
        chk("op_invalid", 16'h0001, {15'h0000, op_invalid});
        chk("margin_state", 16'h0002, {14'h0000, margin_state});
        op_set(8'h80);
    endtask
    task t_clamp;
        wr(8'h21, 16'h3000);
        cycles(3);
        chk("target_out", 16'h2333, target_out);
        wr(8'h21, 16'h2000);
        wr(8'h23, 16'hFF00);
        cycles(3);
        chk("target_out", 16'h1F00, target_out);
        wr(8'h23, 16'h0400);
        op_set(8'hA4);
        chk("target_out", 16'h2333, target_out);
        wr(8'h23, 16'h0000);
        op_set(8'h80);
    endtask
    task t_ramp;
        int k;
        unit_running <= 1'h1;
        op_set(8'h94);
        cycles(20);
        chk("ramp_active", 16'h0001, {15'h0000, ramp_active});
        chk("ramp midway", 16'h0001, {15'h0000, target_out < 16'h2000 && target_out > 16'h1FD0});
        // roughly 500 cycles at 1 V/ms; bound leaves twice that
        for (k = 0; k < 1000 && target_out !== 16'h1E66; k++)
            @(negedge core_clk);
        chk("target_out", 16'h1E66, target_out);
        if (target_out !== 16'h1E66)
            conclude();
        wr(8'h27, 16'h7BFF);
        op_set(8'h80);
        chk("target_out", 16'h2000, target_out);
        wr(8'h27, 16'hBA00);
    endtask
    task t_restrap;
        // new strap, then a mid-run reset of two edges
        @(posedge core_clk);
        strap_target <= 16'h3000;
        unit_running <= 1'h0;
        cycles(2);
        sys_rst      <= 1'h1;
        cycles(2);
        sys_rst      <= 1'h0;
        cycles(1);
        rdchk(8'h21, 16'h3000);
        rdchk(8'h23, 16'h0000);
        rdchk(8'h24, 16'h34CC);
        rdchk(8'h25, 16'h3266);
        rdchk(8'h26, 16'h2D99);
        rdchk(8'h27, 16'hBA00);
        chk("target_out", 16'h3000, target_out);
    endtask
    initial
    begin
        // reset spans two edges; the bank reloads its strapped defaults on the edge after release
        cycles(2);
        sys_rst <= 1'h0;
        cycles(1);
        t_defaults;
        t_access;
        t_margins;
        t_clamp;
        t_ramp;
        t_restrap;
        conclude;
    end
endmodule
